// file: common/output_stage_pkg.sv
// Operation
// - power field 11 in tuning register puts headphone stages in lineout mode.
// - two-bit common-mode field picks one of four headphone output levels.
// - bit 7 powers left headphone driver, bit 6 the right one.
// - each headphone gain register holds gain bits 6..3 and mute bit 2.
// - headphone short detection always on; bit 1 picks limit(0) or shutdown(1).
// - headphone short on either channel sets read-only flag bit 0.
// - in shutdown mode a short clears that channel's headphone power bit.
// - software sets power bit again to retry; persisting fault shuts down again.
// - hardware or software master reset returns every register to default.
// - bit 7 powers left speaker stage, bit 6 the right one.
// - each speaker gain register holds gain bits 4..3 and mute bit 2.
// - speaker overcurrent always shuts stage down and sets read-only flag bit 0.
// - speaker power bit set again retries; persisting fault shuts down again.
// - over-temperature stops speaker switching until cool; flag bit 1 reports it.
// - select pin governs stage power only when pin-function field is 11.
// - under pin control pin 0 powers speakers, 1 powers headphones, never both.
// - under register control all four stages may be on; each soft-starts.
package output_stage_pkg;
   // register indices, byte address is four times the index
   localparam logic [6:0] IDX_OVERTEMP_STATUS   = 7'h03;
   localparam logic [6:0] IDX_HP_POWER_TUNING   = 7'h2c;
   localparam logic [6:0] IDX_OUT_SEL_PIN_CFG   = 7'h39;
   localparam logic [6:0] IDX_HP_DRIVER_CTRL    = 7'h1f;
   localparam logic [6:0] IDX_SPK_DRIVER_CTRL   = 7'h20;
   localparam logic [6:0] IDX_LEFT_HP_GAIN      = 7'h28;
   localparam logic [6:0] IDX_RIGHT_HP_GAIN     = 7'h29;
   localparam logic [6:0] IDX_LEFT_SPK_GAIN     = 7'h2a;
   localparam logic [6:0] IDX_RIGHT_SPK_GAIN    = 7'h2b;
   localparam logic [6:0] IDX_IRQ_STATUS        = 7'h40;
   localparam logic [6:0] IDX_IRQ_ENABLE        = 7'h41;
   localparam logic [6:0] IDX_IRQ_CLEAR         = 7'h42;
   localparam logic [6:0] IDX_SOFT_RESET        = 7'h43;

   localparam int BIT_LEFT_PWR    = 7;
   localparam int BIT_RIGHT_PWR   = 6;
   localparam int BIT_CM_HI       = 4;
   localparam int BIT_CM_LO       = 3;
   localparam int BIT_SHORT_MODE  = 1;
   localparam int BIT_FAULT_FLAG  = 0;
   localparam int BIT_OVERTEMP    = 1;
   localparam int BIT_FIELD_HI    = 2;
   localparam int BIT_FIELD_LO    = 1;
   localparam int BIT_SOFT_RESET  = 0;

   localparam logic [1:0] LINEOUT_MODE  = 2'h3;
   localparam logic [1:0] PIN_FUNC_SEL  = 2'h3;

   localparam logic [7:0] RESET_REG     = 8'h00;
   localparam logic [2:0] RESET_IRQ     = 3'h0;

   // interrupt bits
   localparam int IRQ_HP_SHORT  = 0;
   localparam int IRQ_SPK_SHORT = 1;
   localparam int IRQ_OVERTEMP  = 2;

   // stage order in the enable vector
   localparam int STG_HPL = 3;
   localparam int STG_HPR = 2;
   localparam int STG_SPL = 1;
   localparam int STG_SPR = 0;

   localparam int         SOFT_START_NS     = 400;
   localparam int         CLK_PERIOD_NS     = 25;
   localparam logic [4:0] SOFT_START_CYCLES =
      5'((SOFT_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage

// file: verilog/output_stage_power_protect.sv
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
module output_stage_power_protect (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [11:0] awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   input  wire logic [11:0] araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   input  wire logic        hp_short_left,
   input  wire logic        hp_short_right,
   input  wire logic        spk_short_left,
   input  wire logic        spk_short_right,
   input  wire logic        die_overtemp,
   input  wire logic        output_select_input_pin,
   output logic             left_headphone_driver_en,
   output logic             right_headphone_driver_en,
   output logic             left_speaker_stage_en,
   output logic             right_speaker_stage_en,
   output logic [3:0]       soft_start_busy,
   output logic             speaker_switch_en,
   output logic             hp_current_limit,
   output logic             hp_lineout_mode,
   output logic [1:0]       hp_common_mode,
   output logic [3:0]       left_hp_gain,
   output logic             left_hp_mute,
   output logic [3:0]       right_hp_gain,
   output logic             right_hp_mute,
   output logic [1:0]       left_spk_gain,
   output logic             left_spk_mute,
   output logic [1:0]       right_spk_gain,
   output logic             right_spk_mute,
   output logic             irq
);

   typedef struct packed {
      logic            aw_full;
      logic [6:0]      aw_idx;
      logic [2:0]      aw_top;
      logic            w_full;
      logic [7:0]      w_data;
      logic            w_lane0;
      logic            awready;
      logic            wready;
      logic            bvalid;
      logic [1:0]      bresp;
      logic            arready;
      logic            rvalid;
      logic [31:0]     rdata;
      logic [1:0]      rresp;
      logic [7:0]      hp_tune;
      logic [7:0]      pin_cfg;
      logic [7:0]      hp_ctrl;
      logic [7:0]      spk_ctrl;
      logic [7:0]      hpl_gain;
      logic [7:0]      hpr_gain;
      logic [7:0]      spl_gain;
      logic [7:0]      spr_gain;
      logic            overtemp;
      logic [2:0]      irq_status;
      logic [2:0]      irq_enable;
      logic            irq;
      logic            sel_meta;
      logic            sel_sync;
      logic [3:0]      stage_en;
      logic [3:0][4:0] ss_cnt;
      logic            spk_switch;
   } state_s;

   state_s s_q;
   state_s s_d;

   function automatic logic [6:0] addr_to_idx(input logic [11:0] addr);
      addr_to_idx = addr[8:2];
   endfunction

   function automatic logic idx_mapped(input logic [6:0] idx, input logic [11:0] addr);
      idx_mapped = (addr[11:9] == 3'h0) && (
         idx == output_stage_pkg::IDX_OVERTEMP_STATUS ||
         idx == output_stage_pkg::IDX_HP_POWER_TUNING ||
         idx == output_stage_pkg::IDX_OUT_SEL_PIN_CFG ||
         idx == output_stage_pkg::IDX_HP_DRIVER_CTRL ||
         idx == output_stage_pkg::IDX_SPK_DRIVER_CTRL ||
         idx == output_stage_pkg::IDX_LEFT_HP_GAIN ||
         idx == output_stage_pkg::IDX_RIGHT_HP_GAIN ||
         idx == output_stage_pkg::IDX_LEFT_SPK_GAIN ||
         idx == output_stage_pkg::IDX_RIGHT_SPK_GAIN ||
         idx == output_stage_pkg::IDX_IRQ_STATUS ||
         idx == output_stage_pkg::IDX_IRQ_ENABLE ||
         idx == output_stage_pkg::IDX_IRQ_CLEAR ||
         idx == output_stage_pkg::IDX_SOFT_RESET);
   endfunction

   always_comb begin
      logic       do_write;
      logic       wr_ok;
      logic       soft_rst;
      logic [7:0] wd;
      logic [6:0] ridx;
      logic       hp_short;
      logic       spk_short;
      logic       pin_mode;
      logic [3:0] want;
      logic [2:0] events;
      s_d       = s_q;
      do_write  = 1'b0;
      wr_ok     = 1'b0;
      soft_rst  = 1'b0;
      wd        = s_q.w_data;
      ridx      = addr_to_idx(araddr);
      hp_short  = hp_short_left | hp_short_right;
      spk_short = spk_short_left | spk_short_right;
      pin_mode  = 1'b0;
      want      = 4'h0;
      events    = 3'h0;

      // write channels are taken independently and joined here
      if (awvalid && s_q.awready) begin
         s_d.aw_full = 1'b1;
         s_d.aw_idx  = addr_to_idx(awaddr);
         s_d.aw_top  = awaddr[11:9];
      end
      if (wvalid && s_q.wready) begin
         s_d.w_full  = 1'b1;
         s_d.w_data  = wdata[7:0];
         s_d.w_lane0 = wstrb[0];
      end
      if (s_q.bvalid && bready) begin
         s_d.bvalid = 1'b0;
      end
      if (s_q.aw_full && s_q.w_full && !s_q.bvalid) begin
         do_write    = s_q.w_lane0;
         wr_ok       = idx_mapped(s_q.aw_idx, {s_q.aw_top, s_q.aw_idx, 2'h0});
         s_d.aw_full = 1'b0;
         s_d.w_full  = 1'b0;
         s_d.bvalid  = 1'b1;
         s_d.bresp   = wr_ok ? output_stage_pkg::RESP_OKAY : output_stage_pkg::RESP_DECERR;
      end

      if (do_write && wr_ok) begin
         case (s_q.aw_idx)
            output_stage_pkg::IDX_HP_POWER_TUNING: s_d.hp_tune = wd;
            output_stage_pkg::IDX_OUT_SEL_PIN_CFG: s_d.pin_cfg = wd;
            output_stage_pkg::IDX_HP_DRIVER_CTRL: begin
               // flag bit is read-only; a retry write clears it
               s_d.hp_ctrl = {wd[7:1], 1'b0};
            end
            output_stage_pkg::IDX_SPK_DRIVER_CTRL: begin
               s_d.spk_ctrl = {wd[7:1], 1'b0};
            end
            output_stage_pkg::IDX_LEFT_HP_GAIN:   s_d.hpl_gain = wd;
            output_stage_pkg::IDX_RIGHT_HP_GAIN:  s_d.hpr_gain = wd;
            output_stage_pkg::IDX_LEFT_SPK_GAIN:  s_d.spl_gain = wd;
            output_stage_pkg::IDX_RIGHT_SPK_GAIN: s_d.spr_gain = wd;
            output_stage_pkg::IDX_IRQ_ENABLE:     s_d.irq_enable = wd[2:0];
            output_stage_pkg::IDX_IRQ_CLEAR:      s_d.irq_status = s_q.irq_status & ~wd[2:0];
            output_stage_pkg::IDX_SOFT_RESET:     soft_rst = wd[output_stage_pkg::BIT_SOFT_RESET];
            default: ;
         endcase
      end

      // shutdown mode clears the faulted channel's power bit after any write,
      // so a retry into a persisting short is dropped again at once
      if (hp_short) begin
         s_d.hp_ctrl[output_stage_pkg::BIT_FAULT_FLAG] = 1'b1;
      end
      if (s_q.hp_ctrl[output_stage_pkg::BIT_SHORT_MODE]) begin
         if (hp_short_left) begin
            s_d.hp_ctrl[output_stage_pkg::BIT_LEFT_PWR] = 1'b0;
         end
         if (hp_short_right) begin
            s_d.hp_ctrl[output_stage_pkg::BIT_RIGHT_PWR] = 1'b0;
         end
      end
      // no current limit on the speaker path: always shut down
      if (spk_short) begin
         s_d.spk_ctrl[output_stage_pkg::BIT_FAULT_FLAG] = 1'b1;
      end
      if (spk_short_left) begin
         s_d.spk_ctrl[output_stage_pkg::BIT_LEFT_PWR] = 1'b0;
      end
      if (spk_short_right) begin
         s_d.spk_ctrl[output_stage_pkg::BIT_RIGHT_PWR] = 1'b0;
      end

      s_d.overtemp = die_overtemp;

      // interrupt events, set wins over a clear in the same cycle
      events[output_stage_pkg::IRQ_HP_SHORT]  = hp_short;
      events[output_stage_pkg::IRQ_SPK_SHORT] = spk_short;
      events[output_stage_pkg::IRQ_OVERTEMP]  = die_overtemp & ~s_q.overtemp;
      s_d.irq_status = s_d.irq_status | events;

      // first stage feeds only the second
      s_d.sel_meta = output_select_input_pin;
      s_d.sel_sync = s_q.sel_meta;

      if (soft_rst) begin
         s_d.hp_tune    = output_stage_pkg::RESET_REG;
         s_d.pin_cfg    = output_stage_pkg::RESET_REG;
         s_d.hp_ctrl    = output_stage_pkg::RESET_REG;
         s_d.spk_ctrl   = output_stage_pkg::RESET_REG;
         s_d.hpl_gain   = output_stage_pkg::RESET_REG;
         s_d.hpr_gain   = output_stage_pkg::RESET_REG;
         s_d.spl_gain   = output_stage_pkg::RESET_REG;
         s_d.spr_gain   = output_stage_pkg::RESET_REG;
         s_d.irq_status = output_stage_pkg::RESET_IRQ;
         s_d.irq_enable = output_stage_pkg::RESET_IRQ;
      end

      pin_mode = s_d.pin_cfg[output_stage_pkg::BIT_FIELD_HI:output_stage_pkg::BIT_FIELD_LO]
                 == output_stage_pkg::PIN_FUNC_SEL;
      want[output_stage_pkg::STG_HPL] = s_d.hp_ctrl[output_stage_pkg::BIT_LEFT_PWR];
      want[output_stage_pkg::STG_HPR] = s_d.hp_ctrl[output_stage_pkg::BIT_RIGHT_PWR];
      want[output_stage_pkg::STG_SPL] = s_d.spk_ctrl[output_stage_pkg::BIT_LEFT_PWR];
      want[output_stage_pkg::STG_SPR] = s_d.spk_ctrl[output_stage_pkg::BIT_RIGHT_PWR];
      if (pin_mode) begin
         // only one group can be powered while the pin rules
         if (s_q.sel_sync) begin
            want = want & 4'hc;
         end else begin
            want = want & 4'h3;
         end
      end
      s_d.stage_en = want;

      // each newly enabled stage ramps for a fixed time
      for (int i = 0; i < 4; i++) begin
         if (want[i] && !s_q.stage_en[i]) begin
            s_d.ss_cnt[i] = output_stage_pkg::SOFT_START_CYCLES;
         end else if (!want[i]) begin
            s_d.ss_cnt[i] = 5'h00;
         end else if (s_q.ss_cnt[i] != 5'h00) begin
            s_d.ss_cnt[i] = s_q.ss_cnt[i] - 5'h01;
         end
      end

      s_d.spk_switch = !die_overtemp;
      s_d.irq        = |(s_d.irq_status & s_d.irq_enable);

      // read path, one read in flight
      if (s_q.rvalid && rready) begin
         s_d.rvalid = 1'b0;
      end
      if (arvalid && s_q.arready) begin
         s_d.rvalid = 1'b1;
         s_d.rdata  = 32'h0000_0000;
         s_d.rresp  = idx_mapped(ridx, araddr) ? output_stage_pkg::RESP_OKAY
                                                : output_stage_pkg::RESP_DECERR;
         if (idx_mapped(ridx, araddr)) begin
            case (ridx)
               output_stage_pkg::IDX_OVERTEMP_STATUS:
                  s_d.rdata[output_stage_pkg::BIT_OVERTEMP] = s_q.overtemp;
               output_stage_pkg::IDX_HP_POWER_TUNING: s_d.rdata[7:0] = s_q.hp_tune;
               output_stage_pkg::IDX_OUT_SEL_PIN_CFG: s_d.rdata[7:0] = s_q.pin_cfg;
               output_stage_pkg::IDX_HP_DRIVER_CTRL:  s_d.rdata[7:0] = s_q.hp_ctrl;
               output_stage_pkg::IDX_SPK_DRIVER_CTRL: s_d.rdata[7:0] = s_q.spk_ctrl;
               output_stage_pkg::IDX_LEFT_HP_GAIN:    s_d.rdata[7:0] = s_q.hpl_gain;
               output_stage_pkg::IDX_RIGHT_HP_GAIN:   s_d.rdata[7:0] = s_q.hpr_gain;
               output_stage_pkg::IDX_LEFT_SPK_GAIN:   s_d.rdata[7:0] = s_q.spl_gain;
               output_stage_pkg::IDX_RIGHT_SPK_GAIN:  s_d.rdata[7:0] = s_q.spr_gain;
               output_stage_pkg::IDX_IRQ_STATUS:      s_d.rdata[2:0] = s_q.irq_status;
               output_stage_pkg::IDX_IRQ_ENABLE:      s_d.rdata[2:0] = s_q.irq_enable;
               default: ;
            endcase
         end
      end
      // ready flags are registered so no output depends combinationally on an input
      s_d.awready = !s_d.aw_full;
      s_d.wready  = !s_d.w_full;
      s_d.arready = !s_d.rvalid;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign awready                   = s_q.awready;
   assign wready                    = s_q.wready;
   assign bvalid                    = s_q.bvalid;
   assign bresp                     = s_q.bresp;
   assign arready                   = s_q.arready;
   assign rvalid                    = s_q.rvalid;
   assign rdata                     = s_q.rdata;
   assign rresp                     = s_q.rresp;
   assign left_headphone_driver_en  = s_q.stage_en[output_stage_pkg::STG_HPL];
   assign right_headphone_driver_en = s_q.stage_en[output_stage_pkg::STG_HPR];
   assign left_speaker_stage_en     = s_q.stage_en[output_stage_pkg::STG_SPL];
   assign right_speaker_stage_en    = s_q.stage_en[output_stage_pkg::STG_SPR];
   assign soft_start_busy[0]        = s_q.ss_cnt[0] != 5'h00;
   assign soft_start_busy[1]        = s_q.ss_cnt[1] != 5'h00;
   assign soft_start_busy[2]        = s_q.ss_cnt[2] != 5'h00;
   assign soft_start_busy[3]        = s_q.ss_cnt[3] != 5'h00;
   assign speaker_switch_en         = s_q.spk_switch;
   assign hp_current_limit          = !s_q.hp_ctrl[output_stage_pkg::BIT_SHORT_MODE];
   assign hp_lineout_mode           =
      s_q.hp_tune[output_stage_pkg::BIT_FIELD_HI:output_stage_pkg::BIT_FIELD_LO]
      == output_stage_pkg::LINEOUT_MODE;
   assign hp_common_mode            =
      s_q.hp_ctrl[output_stage_pkg::BIT_CM_HI:output_stage_pkg::BIT_CM_LO];
   assign left_hp_gain              = s_q.hpl_gain[6:3];
   assign left_hp_mute              = s_q.hpl_gain[2];
   assign right_hp_gain             = s_q.hpr_gain[6:3];
   assign right_hp_mute             = s_q.hpr_gain[2];
   assign left_spk_gain             = s_q.spl_gain[4:3];
   assign left_spk_mute             = s_q.spl_gain[2];
   assign right_spk_gain            = s_q.spr_gain[4:3];
   assign right_spk_mute            = s_q.spr_gain[2];
   assign irq                       = s_q.irq;

endmodule // output_stage_power_protect
`default_nettype wire

// file: testbench/stage_load_model.sv
`timescale 1ns/100ps
`default_nettype none
module stage_load_model (
   input  wire logic       aclk,
   input  wire logic       slow,
   input  wire logic       hot_cmd,
   input  wire logic [3:0] short_cmd,
   input  wire logic [3:0] stage_en,
   output logic            hp_short_left,
   output logic            hp_short_right,
   output logic            spk_short_left,
   output logic            spk_short_right,
   output logic            die_overtemp
);
   logic [3:0] now_d;
   logic [3:0] late_q;
   // a shorted load draws excess current only while its stage drives it,
   // so a retry into a standing fault trips again
   assign now_d = short_cmd & stage_en;
   always_ff @(posedge aclk) begin
      late_q <= now_d;
   end
   // slow sensing lags a cycle but never reports an undriven stage
   assign {hp_short_left, hp_short_right, spk_short_left, spk_short_right} =
      slow ? (late_q & stage_en) : now_d;
   assign die_overtemp = hot_cmd;
endmodule // stage_load_model
`default_nettype wire

// file: testbench/stage_props.sv
`timescale 1ns/100ps
`default_nettype none
module stage_props (
   input wire logic       aclk, aresetn, awvalid, awready, wvalid, wready,
   input wire logic       bvalid, arvalid, arready, rvalid, irq,
   input wire logic       hp_short_left, spk_short_right, die_overtemp,
   input wire logic       left_headphone_driver_en, right_speaker_stage_en,
   input wire logic       left_speaker_stage_en, speaker_switch_en, hp_current_limit,
   input wire logic [3:0] soft_start_busy
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_hp_short_off: assert property (
      !hp_current_limit && hp_short_left && left_headphone_driver_en
      |=> !left_headphone_driver_en) else $error("headphone stage kept on");
   a_hp_limit_keep: assert property (
      hp_current_limit && hp_short_left && left_headphone_driver_en && !awvalid && !wvalid
      |=> left_headphone_driver_en) else $error("limit mode dropped power");
   a_spk_short_off: assert property (
      spk_short_right && right_speaker_stage_en |=> !right_speaker_stage_en)
      else $error("speaker stage kept on");
   a_otp_stop: assert property (
      die_overtemp [*2] |-> !speaker_switch_en) else $error("switching while hot");
   a_otp_resume: assert property (
      (aresetn && !die_overtemp) [*2] |-> speaker_switch_en) else $error("switching not resumed");
   a_soft_start_run: assert property (
      $rose(left_speaker_stage_en) |-> ##[0:1] soft_start_busy[1] [*8])
      else $error("soft start too short");
   // reset must win over everything, so this one is never disabled
   a_irq_reset_low: assert property (
      disable iff (1'b0) !aresetn |=> !irq) else $error("irq high after reset");
   a_write_answer: assert property (
      awvalid && awready && wvalid && wready && !bvalid |-> ##2 bvalid)
      else $error("no write answer");
   a_read_answer: assert property (
      arvalid && arready |=> rvalid) else $error("no read answer");
   c_hp_shut: cover property (!hp_current_limit && $fell(left_headphone_driver_en));
   c_otp: cover property ($fell(speaker_switch_en));
   c_irq: cover property ($rose(irq));
endmodule // stage_props
bind output_stage_power_protect stage_props i_props (.aclk, .aresetn, .awvalid, .awready,
   .wvalid, .wready, .bvalid, .arvalid, .arready, .rvalid, .irq, .hp_short_left,
   .spk_short_right, .die_overtemp, .left_headphone_driver_en, .right_speaker_stage_en,
   .left_speaker_stage_en, .speaker_switch_en, .hp_current_limit, .soft_start_busy);
`default_nettype wire

// file: testbench/audio_output_stage_power_protect_test.sv
`timescale 1ns/100ps
`default_nettype none
module audio_output_stage_power_protect_test;
   localparam logic [6:0] hpc = output_stage_pkg::IDX_HP_DRIVER_CTRL;
   localparam logic [6:0] spc = output_stage_pkg::IDX_SPK_DRIVER_CTRL;
   localparam logic [6:0] hpg = output_stage_pkg::IDX_LEFT_HP_GAIN;
   localparam logic [4:0][6:0] rest = {output_stage_pkg::IDX_OVERTEMP_STATUS, spc, hpc,
      output_stage_pkg::IDX_HP_POWER_TUNING, output_stage_pkg::IDX_OUT_SEL_PIN_CFG};
   logic        aclk = 1'h0, aresetn = 1'h0, slow = 1'h0, hot = 1'h0;
   logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic [11:0] awaddr = 12'h0, araddr = 12'h0;
   logic [31:0] wdata = 32'h0, rdata;
   logic [3:0]  short_cmd = 4'h0, en, soft_start_busy, left_hp_gain, right_hp_gain;
   logic [1:0]  bresp, rresp, r, hp_common_mode, left_spk_gain, right_spk_gain;
   logic        output_select_input_pin = 1'h0, awready, wready, bvalid, arready, rvalid;
   logic        left_headphone_driver_en, right_headphone_driver_en, irq;
   logic        left_speaker_stage_en, right_speaker_stage_en, speaker_switch_en;
   logic        hp_current_limit, hp_lineout_mode, left_hp_mute, right_hp_mute;
   logic        left_spk_mute, right_spk_mute, hp_short_left, hp_short_right;
   logic        spk_short_left, spk_short_right, die_overtemp;
   logic [7:0]  v, w, q;
   int          bad_count = 0, checks = 0, seed = 11, cyc = 0;
   assign en = {left_headphone_driver_en, right_headphone_driver_en,
                left_speaker_stage_en, right_speaker_stage_en};
   output_stage_power_protect i_dut (.aclk, .aresetn, .awaddr, .awvalid, .awready,
      .wdata, .wstrb(4'hf), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
      .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .hp_short_left,
      .hp_short_right, .spk_short_left, .spk_short_right, .die_overtemp,
      .output_select_input_pin, .left_headphone_driver_en, .right_headphone_driver_en,
      .left_speaker_stage_en, .right_speaker_stage_en, .soft_start_busy,
      .speaker_switch_en, .hp_current_limit, .hp_lineout_mode, .hp_common_mode,
      .left_hp_gain, .left_hp_mute, .right_hp_gain, .right_hp_mute, .left_spk_gain,
      .left_spk_mute, .right_spk_gain, .right_spk_mute, .irq);
   stage_load_model i_load (.aclk, .slow, .hot_cmd(hot), .short_cmd, .stage_en(en),
      .hp_short_left, .hp_short_right, .spk_short_left, .spk_short_right, .die_overtemp);
   initial begin
      forever #12.5 aclk = ~aclk;
   end
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // a hang counts as a mismatch; the full run needs about 460 cycles
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         bad_count++;
         print_verdict;
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("FAIL %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge aclk);
   endtask
   task automatic wr(input logic [6:0] ix, input logic [7:0] d, output logic [1:0] rs);
      @(posedge aclk);
      awaddr <= {3'h0, ix, 2'h0};
      wdata <= {24'h0, d};
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'h0;
         if (wready) wvalid <= 1'h0;
      end while (bvalid !== 1'h1);
      rs = bresp;
      bready <= 1'h0;
   endtask
   task automatic rd(input logic [6:0] ix, output logic [7:0] d, output logic [1:0] rs);
      @(posedge aclk);
      araddr <= {3'h0, ix, 2'h0};
      arvalid <= 1'h1;
      rready <= 1'h1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'h0;
      end while (rvalid !== 1'h1);
      d = rdata[7:0];
      rs = rresp;
      rready <= 1'h0;
   endtask
   task automatic rchk(input logic [6:0] ix, input logic [7:0] e);
      rd(ix, q, r);
      chk(q, e);
      chk(r, output_stage_pkg::RESP_OKAY);
   endtask
   function automatic logic [3:0] exp_en(logic [1:0] f, logic p, logic [7:0] h, logic [7:0] s);
      return {h[7:6], s[7:6]} & ((f == 2'h3) ? (p ? 4'hc : 4'h3) : 4'hf);
   endfunction
   initial begin
      repeat (6) @(posedge aclk);
      aresetn <= 1'h1;
      idle(2);
      for (int k = 0; k < 9; k++) rchk(k < 4 ? hpg + 7'(k) : rest[k - 4], 8'h00);
      rd(7'h10, q, r);
      chk(r, output_stage_pkg::RESP_DECERR);
      wr(7'h10, 8'hff, r);
      chk(r, output_stage_pkg::RESP_DECERR);
      $display("test reset and map done");
      for (int i = 0; i < 4; i++) begin
         wr(output_stage_pkg::IDX_HP_POWER_TUNING, 8'(i << 1), r);
         wr(hpc, 8'(i << 3), r);
         idle(2);
         chk(hp_lineout_mode, i == 3);
         chk(hp_common_mode, i);
      end
      repeat (8) begin
         v = 8'($random(seed));
         w = ~v;
         for (int k = 0; k < 4; k++) wr(hpg + 7'(k), k[0] ? w : v, r);
         idle(2);
         chk({left_hp_gain, left_hp_mute}, v[6:2]);
         chk({right_hp_gain, right_hp_mute}, w[6:2]);
         chk({left_spk_gain, left_spk_mute}, v[4:2]);
         chk({right_spk_gain, right_spk_mute}, w[4:2]);
         rd(hpg, q, r);
         chk(q[6:2], v[6:2]);
      end
      $display("test fields done");
      wr(hpc, 8'hc0, r);
      wr(spc, 8'hc0, r);
      idle(20);
      chk(en, 4'hf);
      chk(hp_current_limit, 1'h1);
      wr(output_stage_pkg::IDX_IRQ_ENABLE, 8'h01, r);
      short_cmd <= 4'h8;
      idle(4);
      chk({en, irq}, 5'h1f);
      rchk(hpc, 8'hc1);
      short_cmd <= 4'h0;
      wr(output_stage_pkg::IDX_IRQ_CLEAR, 8'h07, r);
      idle(2);
      chk(irq, 1'h0);
      wr(output_stage_pkg::IDX_IRQ_ENABLE, 8'h00, r);
      short_cmd <= 4'h8;
      idle(4);
      chk(irq, 1'h0);
      rchk(output_stage_pkg::IDX_IRQ_STATUS, 8'h01);
      short_cmd <= 4'h0;
      wr(output_stage_pkg::IDX_IRQ_CLEAR, 8'h07, r);
      $display("test limit and irq done");
      wr(hpc, 8'hc2, r);
      slow <= 1'h1;
      short_cmd <= 4'h8;
      idle(4);
      chk(en, 4'h7);
      rchk(hpc, 8'h43);
      // two retries into the standing fault, each one shut down again
      repeat (2) begin
         wr(hpc, 8'hc2, r);
         idle(4);
         chk(en, 4'h7);
      end
      short_cmd <= 4'h0;
      slow <= 1'h0;
      wr(hpc, 8'hc2, r);
      idle(3);
      chk(en, 4'hf);
      rchk(hpc, 8'hc2);
      short_cmd <= 4'h1;
      idle(4);
      chk(en, 4'he);
      rchk(spc, 8'h81);
      short_cmd <= 4'h0;
      wr(spc, 8'hc0, r);
      idle(3);
      chk(en, 4'hf);
      chk(soft_start_busy, 4'h1);
      $display("test shutdown done");
      hot <= 1'h1;
      idle(3);
      chk(speaker_switch_en, 1'h0);
      rchk(output_stage_pkg::IDX_OVERTEMP_STATUS, 8'h02);
      hot <= 1'h0;
      idle(3);
      chk(speaker_switch_en, 1'h1);
      wr(output_stage_pkg::IDX_OUT_SEL_PIN_CFG, 8'h06, r);
      repeat (10) begin
         output_select_input_pin <= 1'($random(seed));
         idle(5);
         chk(en, exp_en(2'h3, output_select_input_pin, 8'hc2, 8'hc0));
      end
      wr(output_stage_pkg::IDX_OUT_SEL_PIN_CFG, 8'h02, r);
      idle(3);
      chk(en, exp_en(2'h1, output_select_input_pin, 8'hc2, 8'hc0));
      $display("test overtemp and pin done");
      wr(output_stage_pkg::IDX_SOFT_RESET, 8'h01, r);
      idle(2);
      chk(en, 4'h0);
      rchk(hpc, 8'h00);
      wr(spc, 8'hc0, r);
      aresetn <= 1'h0;
      idle(6);
      aresetn <= 1'h1;
      idle(2);
      chk(en, 4'h0);
      rchk(spc, 8'h00);
      $display("test resets done");
      print_verdict;
   end
endmodule // audio_output_stage_power_protect_test
`default_nettype wire
